// >>> verilog/fault_alert_pkg.sv
// Package with offsets, bit positions, reset values and timing for the fault alert bank
package fault_alert_pkg;

  // Register offsets on the serial link register space
  localparam logic [7:0]  STATUS_OFS      = 8'h02;
  localparam logic [7:0]  FMEA_OFS        = 8'h03;
  localparam logic [7:0]  CELL_ALERT_OFS  = 8'h04;

  // Values after reset
  localparam logic [15:0] FMEA_RST        = 16'h0000;
  localparam logic [15:0] CELL_ALERT_RST  = 16'h0000;
  localparam logic        POR_FLAG_RST    = 1'b1;
  // Oscillator synchroniser level after reset; high, so no false rise follows
  localparam logic        OSC_SYNC_RST    = 1'b1;

  // Bit positions in failure_mode_alerts_one
  localparam int OSC_PRI_BIT    = 15;
  localparam int OSC_RED_BIT    = 14;
  localparam int FMEA_ZERO_BIT  = 13;
  localparam int UP_SE_BIT      = 12;
  localparam int LO_SE_BIT      = 11;
  localparam int UP_SE_B_BIT    = 10;
  localparam int LO_SE_B_BIT    = 9;
  localparam int SUP3_UV_BIT    = 8;
  localparam int SUP2_UV_BIT    = 7;
  localparam int GND2_OPEN_BIT  = 6;
  localparam int BALSW_BIT      = 5;
  localparam int TEMP_BIT       = 4;
  localparam int HV_UV_BIT      = 3;
  localparam int GND3_OPEN_BIT  = 2;
  localparam int SUP1_UV_BIT    = 1;
  localparam int GND1_OPEN_BIT  = 0;
  // Power-on-reset flag position in the status register
  localparam int POR_FLAG_BIT   = 15;
  // Positions in cell_combined_alerts
  localparam int AUX1_BIT       = 13;
  localparam int AUX0_BIT       = 12;

  // Bits cleared only by writing zero
  localparam logic [15:0] STICKY_MASK     = 16'hC1DF;

  // Oscillator check timing
  localparam longint CLK_HZ         = 100_000_000;
  localparam longint OSC_NOM_HZ     = 32_000;
  localparam longint OSC_TOL_PCT    = 5;
  localparam longint OSC_EVAL_CYC   = 2;
  // Clock cycles over one evaluation window at nominal rate
  localparam longint OSC_NOM_CNT    = CLK_HZ * OSC_EVAL_CYC / OSC_NOM_HZ;
  // Least legal count rounds up, largest rounds down
  localparam longint OSC_LO_CNT     = (OSC_NOM_CNT * (100 - OSC_TOL_PCT) + 99) / 100;
  localparam longint OSC_HI_CNT     = OSC_NOM_CNT * (100 + OSC_TOL_PCT) / 100;

endpackage

// >>> verilog/osc_freq_checker.sv
// Window counter that flags an off-frequency low-speed oscillator
`timescale 1ns/1ps
module osc_freq_checker #(
  parameter logic [15:0] P_LO_CNT = 16'h1732,
  parameter logic [15:0] P_HI_CNT = 16'h19A2
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Oscillator under test, asynchronous
  input  wire logic i_osc,
  // Fault found at evaluation or on a stall, one-cycle pulse
  output logic      o_fault
);
  import fault_alert_pkg::*;

  logic        sync1_q;   // First synchroniser stage
  logic        sync2_q;   // Second synchroniser stage
  logic        prev_q;    // Delayed copy for edge detect
  logic        half_q;    // Odd rising edge seen
  logic        started_q; // Window aligned to a real edge
  logic [15:0] cnt_q;     // Clock cycles in current window
  logic        rise;      // Rising edge of oscillator
  logic        eval;      // Window closes on second edge
  logic        stall;     // No edge came in time
  logic        bad;       // Window out of tolerance

  assign rise  = sync2_q & ~prev_q;
  assign eval  = rise & half_q;
  assign stall = (cnt_q > P_HI_CNT);
  assign bad   = (eval & ((cnt_q < P_LO_CNT) | (cnt_q > P_HI_CNT))) | stall;

  // Synchroniser and edge history
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // All high, so a pin already high at release shows no rise
      sync1_q <= OSC_SYNC_RST;
      sync2_q <= OSC_SYNC_RST;
      prev_q  <= OSC_SYNC_RST;
    end else begin
      sync1_q <= i_osc;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Window every two oscillator cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      half_q    <= 1'b0;
      started_q <= 1'b0;
      cnt_q     <= 16'h0000;
      o_fault   <= 1'b0;
    end else begin
      o_fault <= bad;
      if (eval | stall) begin
        // Closing edge opens the next window; a stall forces realignment
        half_q    <= 1'b0;
        started_q <= eval;
        cnt_q     <= 16'h0000;
      end else if (rise & ~started_q) begin
        // First edge opens the first window, so no partial window is judged
        started_q <= 1'b1;
        cnt_q     <= 16'h0000;
      end else begin
        half_q <= half_q ^ rise;
        cnt_q  <= cnt_q + 16'h0001;
      end
    end
  end

endmodule

// >>> verilog/fault_alert_status_bank.sv
// Failure-mode and combined cell alert registers of the acquisition chip
`timescale 1ns/1ps
module fault_alert_status_bank #(
  parameter logic [15:0] P_OSC_LO_CNT = 16'(fault_alert_pkg::OSC_LO_CNT),
  parameter logic [15:0] P_OSC_HI_CNT = 16'(fault_alert_pkg::OSC_HI_CNT)
) (
  // Clock and power-on reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Register port from the serial link
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_rd,
  output logic [15:0]      o_reg_rdata,
  output logic             o_reg_hit,
  // Low-speed oscillators, asynchronous
  input  wire logic        i_osc_pri,
  input  wire logic        i_osc_red,
  // Receiver mode events from the link, same clock
  input  wire logic        i_upper_se_detect,
  input  wire logic        i_lower_se_detect,
  // Analog fault comparators, asynchronous
  input  wire logic [2:0]  i_logic_supply_uv,
  input  wire logic [2:0]  i_logic_ground_open,
  input  wire logic        i_high_supply_uv,
  input  wire logic        i_die_over_temp,
  // Sequencer events, same clock
  input  wire logic        i_diag_settle_short,
  input  wire logic [11:0] i_balance_switch_alerts,
  // Source alert registers, same clock
  input  wire logic [12:1] i_cell_over_alert,
  input  wire logic [12:1] i_cell_under_alert,
  input  wire logic        i_aux_input1_over_alert,
  input  wire logic        i_aux_input1_under_alert,
  input  wire logic        i_aux_input0_over_alert,
  input  wire logic        i_aux_input0_under_alert,
  // State shown to the rest of the chip
  output logic             o_power_on_reset_flag,
  output logic [15:0]      o_failure_mode_alerts_one,
  output logic [15:0]      o_cell_combined_alerts
);
  import fault_alert_pkg::*;

  // Address match used for both reads and writes
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  logic [7:0]  sync1_q;       // First stage of pin synchronisers
  logic [7:0]  sync2_q;       // Second stage of pin synchronisers
  logic [1:0]  osc_fault;     // Pulses from the two checkers
  logic        por_q;         // power_on_reset_flag
  logic        por_d;
  logic        seen_up_q;     // Upper receiver went single-ended
  logic        seen_lo_q;     // Lower receiver went single-ended
  logic [15:0] fmea_q;        // Sticky part of failure_mode_alerts_one
  logic [15:0] fmea_d;
  logic [15:0] set_vec;       // Set requests this cycle
  logic [15:0] clr_vec;       // Clear requests this cycle
  logic [15:0] fmea_view;     // Full register as read
  logic [15:0] cell_view;     // cell_combined_alerts as read
  logic [15:0] rd_mux;        // Selected read value
  logic        wr_status;     // Write to status offset
  logic        wr_fmea;       // Write to failure mode offset
  logic        hit_any;       // Address is one of ours
  logic        armed;         // Reset flag cleared, gated faults may set
  logic        aux1_alert;    // aux_input1_alert
  logic        aux0_alert;    // aux_input0_alert
  logic        bal_summary;   // balance_switch_alert_summary

  // Two independent oscillator checkers
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_osc
      osc_freq_checker #(
        .P_LO_CNT (P_OSC_LO_CNT),
        .P_HI_CNT (P_OSC_HI_CNT)
      ) u_chk (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_osc   ((g == 0) ? i_osc_pri : i_osc_red),
        .o_fault (osc_fault[g])
      );
    end
  endgenerate

  // Two-flop synchronisers on the comparator pins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {i_die_over_temp, i_high_supply_uv,
                  i_logic_ground_open, i_logic_supply_uv};
      sync2_q <= sync1_q;
    end
  end

  // Address decode
  assign wr_status = i_reg_wr & addr_hit(i_reg_addr, STATUS_OFS);
  assign wr_fmea   = i_reg_wr & addr_hit(i_reg_addr, FMEA_OFS);
  assign hit_any   = addr_hit(i_reg_addr, STATUS_OFS) |
                     addr_hit(i_reg_addr, FMEA_OFS) |
                     addr_hit(i_reg_addr, CELL_ALERT_OFS);

  // Reset flag: writing one has no effect
  assign por_d = por_q & ~(wr_status & ~i_reg_wdata[POR_FLAG_BIT]);
  assign armed = ~por_q;

  // Set requests per bit, gated ones wait for armed
  always_comb begin
    set_vec                = 16'h0000;
    set_vec[OSC_PRI_BIT]   = osc_fault[0];
    set_vec[OSC_RED_BIT]   = osc_fault[1];
    set_vec[SUP1_UV_BIT]   = armed & sync2_q[0];
    set_vec[SUP2_UV_BIT]   = armed & sync2_q[1];
    set_vec[SUP3_UV_BIT]   = armed & sync2_q[2];
    set_vec[GND1_OPEN_BIT] = armed & sync2_q[3];
    set_vec[GND2_OPEN_BIT] = armed & sync2_q[4];
    set_vec[GND3_OPEN_BIT] = armed & sync2_q[5];
    set_vec[HV_UV_BIT]     = armed & sync2_q[6];
    set_vec[TEMP_BIT]      = sync2_q[7] | i_diag_settle_short;
  end

  // Written zero clears, written one keeps; set wins
  assign clr_vec = {16{wr_fmea}} & ~i_reg_wdata;
  assign fmea_d  = STICKY_MASK & (set_vec | (fmea_q & ~clr_vec));

  // Sticky fault and reset flag storage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_q  <= POR_FLAG_RST;
      fmea_q <= FMEA_RST;
    end else begin
      por_q  <= por_d;
      fmea_q <= fmea_d;
    end
  end

  // First-preamble single-ended events, held until power-on reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seen_up_q <= 1'b0;
      seen_lo_q <= 1'b0;
    end else begin
      seen_up_q <= seen_up_q | i_upper_se_detect;
      seen_lo_q <= seen_lo_q | i_lower_se_detect;
    end
  end

  // Combined alerts follow sources live
  assign bal_summary = |i_balance_switch_alerts;
  assign aux1_alert  = i_aux_input1_over_alert | i_aux_input1_under_alert;
  assign aux0_alert  = i_aux_input0_over_alert | i_aux_input0_under_alert;

  // Assemble failure_mode_alerts_one; bit 13 stays zero
  always_comb begin
    fmea_view                = fmea_q;
    fmea_view[FMEA_ZERO_BIT] = 1'b0;
    fmea_view[UP_SE_BIT]     = seen_up_q & armed;
    fmea_view[LO_SE_BIT]     = seen_lo_q & armed;
    fmea_view[UP_SE_B_BIT]   = seen_up_q;
    fmea_view[LO_SE_B_BIT]   = seen_lo_q;
    fmea_view[BALSW_BIT]     = bal_summary;
  end

  // Assemble cell_combined_alerts; top two bits zero
  assign cell_view = {2'b00, aux1_alert, aux0_alert,
                      i_cell_over_alert | i_cell_under_alert};

  // Read selection
  assign rd_mux = addr_hit(i_reg_addr, FMEA_OFS)       ? fmea_view :
                  addr_hit(i_reg_addr, CELL_ALERT_OFS) ? cell_view :
                  addr_hit(i_reg_addr, STATUS_OFS)     ?
                    {por_q, 15'h0000} : 16'h0000;

  // Registered read data, hit flag on every read of a mapped offset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
      o_reg_hit   <= 1'b0;
    end else begin
      o_reg_hit <= i_reg_rd & hit_any;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // State outputs
  assign o_power_on_reset_flag     = por_q;
  assign o_failure_mode_alerts_one = fmea_view;
  assign o_cell_combined_alerts    = cell_view;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  chk_por_clear_zero: assert property (
    wr_status && !i_reg_wdata[POR_FLAG_BIT] |=> !o_power_on_reset_flag)
    else $error("reset flag not cleared by written zero");

  chk_por_never_resets: assert property (
    !o_power_on_reset_flag |=> !o_power_on_reset_flag)
    else $error("reset flag set again without power-on reset");

  chk_osc_fault_sets: assert property (
    osc_fault[0] |=> o_failure_mode_alerts_one[OSC_PRI_BIT])
    else $error("primary oscillator fault not latched");

  chk_osc_red_sets: assert property (
    osc_fault[1] |=> o_failure_mode_alerts_one[OSC_RED_BIT])
    else $error("redundant oscillator fault not latched");

  chk_sticky_held: assert property (
    o_failure_mode_alerts_one[OSC_RED_BIT] && !wr_fmea
    |=> o_failure_mode_alerts_one[OSC_RED_BIT])
    else $error("sticky fault dropped without a write");

  chk_write_one_keeps: assert property (
    wr_fmea && (i_reg_wdata == 16'hFFFF)
    |=> ((o_failure_mode_alerts_one & STICKY_MASK) &
         $past(o_failure_mode_alerts_one & STICKY_MASK))
        == $past(o_failure_mode_alerts_one & STICKY_MASK))
    else $error("writing ones cleared a sticky fault");

  chk_gated_wait_por: assert property (
    o_power_on_reset_flag |-> ((o_failure_mode_alerts_one & 16'h01CF) == 16'h0000))
    else $error("gated fault set while reset flag high");

  chk_se_gate: assert property (
    o_power_on_reset_flag |-> !o_failure_mode_alerts_one[UP_SE_BIT]
                              && !o_failure_mode_alerts_one[LO_SE_BIT])
    else $error("single-ended flag set while reset flag high");

  chk_se_red_early: assert property (
    i_upper_se_detect |=> o_failure_mode_alerts_one[UP_SE_B_BIT])
    else $error("redundant single-ended flag not set");

  chk_balsw_or: assert property (
    o_failure_mode_alerts_one[BALSW_BIT] == (|i_balance_switch_alerts))
    else $error("balance summary differs from OR");

  chk_unused_zero: assert property (
    !o_failure_mode_alerts_one[FMEA_ZERO_BIT] && (o_cell_combined_alerts[15:14] == 2'b00))
    else $error("unused bit reads one");

  chk_cell_or: assert property (
    o_cell_combined_alerts[11:0] == (i_cell_over_alert | i_cell_under_alert)
    && o_cell_combined_alerts[AUX1_BIT] ==
       (i_aux_input1_over_alert | i_aux_input1_under_alert))
    else $error("combined alert differs from sources");

  chk_read_data: assert property (
    i_reg_rd && addr_hit(i_reg_addr, CELL_ALERT_OFS)
    |=> o_reg_rdata == $past(cell_view))
    else $error("read of combined alerts wrong");

  // Register port answers
  chk_hit_on_read: assert property (
    i_reg_rd && hit_any |=> o_reg_hit)
    else $error("hit flag missing after mapped read");

  chk_miss_reads_zero: assert property (
    i_reg_rd && !hit_any |=> !o_reg_hit && (o_reg_rdata == 16'h0000))
    else $error("unmapped read returned data or hit");

  chk_hit_one_cycle: assert property (
    !i_reg_rd |=> !o_reg_hit)
    else $error("hit flag without a read");

  chk_rdata_holds: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  chk_read_status: assert property (
    i_reg_rd && addr_hit(i_reg_addr, STATUS_OFS)
    |=> o_reg_rdata == {$past(o_power_on_reset_flag), 15'h0000})
    else $error("read of reset flag wrong");

  chk_read_fmea: assert property (
    i_reg_rd && addr_hit(i_reg_addr, FMEA_OFS)
    |=> o_reg_rdata == $past(o_failure_mode_alerts_one))
    else $error("read of failure mode register wrong");

  // Sticky set and clear behaviour, then single-ended and aux zero views
  chk_set_latches: assert property (
    (set_vec != 16'h0000)
    |=> (o_failure_mode_alerts_one & $past(set_vec & STICKY_MASK))
        == $past(set_vec & STICKY_MASK))
    else $error("set request lost against a clear");

  chk_zero_clears: assert property (
    wr_fmea && !i_reg_wdata[TEMP_BIT] && !set_vec[TEMP_BIT]
    |=> !o_failure_mode_alerts_one[TEMP_BIT])
    else $error("written zero left die temperature fault");

  chk_temp_short_sets: assert property (
    i_diag_settle_short |=> o_failure_mode_alerts_one[TEMP_BIT])
    else $error("short settling not latched");

  chk_gated_armed: assert property (
    armed && sync2_q[2] |=> o_failure_mode_alerts_one[SUP3_UV_BIT])
    else $error("supply undervoltage not latched");

  chk_se_primary: assert property (
    !o_power_on_reset_flag
    |-> (o_failure_mode_alerts_one[UP_SE_BIT] == o_failure_mode_alerts_one[UP_SE_B_BIT])
        && (o_failure_mode_alerts_one[LO_SE_BIT] == o_failure_mode_alerts_one[LO_SE_B_BIT]))
    else $error("primary single-ended flag differs after reset flag clear");

  chk_se_lower_early: assert property (
    i_lower_se_detect |=> o_failure_mode_alerts_one[LO_SE_B_BIT])
    else $error("redundant lower single-ended flag not set");

  chk_aux0_or: assert property (
    o_cell_combined_alerts[AUX0_BIT] ==
    (i_aux_input0_over_alert | i_aux_input0_under_alert))
    else $error("aux zero alert differs from sources");

endmodule

// >>> dv/host_reg_model.sv
// Host side of the serial register link, issuing single word accesses
`timescale 1ns/1ps
module host_reg_model (
  // Clock
  input  wire logic   i_clk,
  // Register access toward the bank
  output logic [7:0]  o_reg_addr,
  output logic        o_reg_wr,
  output logic [15:0] o_reg_wdata,
  output logic        o_reg_rd
);
  // Idle link at time zero
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 16'h0000;
    o_reg_rd    = 1'b0;
  end
  // One write strobe; data inverted after release so stale data never looks valid
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_clk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~d;
  endtask
  // One read strobe; answer is taken by the bench monitor
  task automatic read_word(input logic [7:0] a);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_clk);
    o_reg_rd   <= 1'b0;
  endtask
endmodule

// >>> dv/fault_alert_status_bank_tb_top.sv
// Self-checking testbench for the fault alert status bank
`timescale 1ns/1ps
module fault_alert_status_bank_tb_top;
  import fault_alert_pkg::*;
  // Clock, reset and register link
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        reg_hit;
  // Oscillators and their half periods in ns, zero means stopped
  logic        osc_pri, osc_red;
  int          pri_hp, red_hp;
  // Fault pins and source alerts
  logic        up_se, lo_se, hv_uv, over_temp, settle_short;
  logic [2:0]  sup_uv, gnd_open;
  logic [11:0] balsw;
  logic [12:1] cell_ov, cell_uv;
  logic        a1o, a1u, a0o, a0u;
  // Live views from the bank
  logic        por_flag;
  logic [15:0] fmea, cell_view;
  // Bookkeeping
  int          n_mismatch, n_tests;
  logic [16:0] exp_q[$];
  logic        rd_d1;
  logic [31:0] seed;
  logic [15:0] exp_cell;

  // Bank with short oscillator window limits
  fault_alert_status_bank #(.P_OSC_LO_CNT(16'h0014), .P_OSC_HI_CNT(16'h003C))
    fault_alert_status_bank_inst (
    .i_clk(clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .o_reg_hit(reg_hit), .i_osc_pri(osc_pri), .i_osc_red(osc_red),
    .i_upper_se_detect(up_se), .i_lower_se_detect(lo_se),
    .i_logic_supply_uv(sup_uv), .i_logic_ground_open(gnd_open),
    .i_high_supply_uv(hv_uv), .i_die_over_temp(over_temp),
    .i_diag_settle_short(settle_short), .i_balance_switch_alerts(balsw),
    .i_cell_over_alert(cell_ov), .i_cell_under_alert(cell_uv),
    .i_aux_input1_over_alert(a1o), .i_aux_input1_under_alert(a1u),
    .i_aux_input0_over_alert(a0o), .i_aux_input0_under_alert(a0u),
    .o_power_on_reset_flag(por_flag), .o_failure_mode_alerts_one(fmea),
    .o_cell_combined_alerts(cell_view));

  // Host model driving the register link
  host_reg_model host_reg_model_inst (
    .i_clk(clk), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr),
    .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Oscillators, unrelated in phase to the clock
  initial begin
    osc_pri = 1'b0;
    forever begin
      if (pri_hp == 0) #10;
      else #(pri_hp) osc_pri = ~osc_pri;
    end
  end
  initial begin
    osc_red = 1'b0;
    #3;
    forever begin
      if (red_hp == 0) #10;
      else #(red_hp) osc_red = ~osc_red;
    end
  end

  // Compare seen and expected, count both
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Note the expected answer, then issue the read
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic h);
    exp_q.push_back({h, e});
    host_reg_model_inst.read_word(a);
  endtask
  // Xorshift source for random stimulus
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Count of results shown, then the verdict
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Answer monitor: read data settles the cycle after the strobe is taken
  always @(posedge clk) rd_d1 <= reg_rd;
  always @(negedge clk) begin
    if (rd_d1) begin
      check({reg_hit, reg_rdata}, exp_q.pop_front());
    end
  end

  // Watchdog against a hung run
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    seed = 32'h7A42;
    {up_se, lo_se, hv_uv, over_temp, settle_short} = 5'h00;
    {sup_uv, gnd_open, balsw} = 18'h00000;
    {cell_ov, cell_uv, a1o, a1u, a0o, a0u} = 28'h0000000;
    pri_hp = 125;
    red_hp = 125;
    {n_mismatch, n_tests, rst_b} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, unmapped place
    rd(FMEA_OFS, FMEA_RST, 1'b1);
    rd(CELL_ALERT_OFS, CELL_ALERT_RST, 1'b1);
    rd(STATUS_OFS, 16'h8000, 1'b1);
    rd(8'h05, 16'h0000, 1'b0);
    // Events while the reset flag is still up: only redundant flags show
    {up_se, lo_se, hv_uv} <= 3'h7;
    {sup_uv, gnd_open} <= 6'h3F;
    repeat (5) @(posedge clk);
    {up_se, lo_se, hv_uv, sup_uv, gnd_open} <= 9'h000;
    repeat (3) @(posedge clk);
    rd(FMEA_OFS, 16'h0600, 1'b1);
    host_reg_model_inst.write_word(STATUS_OFS, 16'hFFFF);
    rd(STATUS_OFS, 16'h8000, 1'b1);
    host_reg_model_inst.write_word(STATUS_OFS, 16'h0000);
    rd(STATUS_OFS, 16'h0000, 1'b1);
    rd(FMEA_OFS, 16'h1E00, 1'b1);
    // Gated faults now latch; settling pulse latches too, balance summary follows balsw live
    {hv_uv, sup_uv, gnd_open, settle_short} <= 8'hFF;
    balsw <= 12'h800;
    @(posedge clk);
    settle_short <= 1'b0;
    repeat (4) @(posedge clk);
    {hv_uv, sup_uv, gnd_open} <= 7'h00;
    repeat (3) @(posedge clk);
    rd(FMEA_OFS, 16'h1FFF, 1'b1);
    host_reg_model_inst.write_word(FMEA_OFS, 16'hFFFF);
    rd(FMEA_OFS, 16'h1FFF, 1'b1);
    host_reg_model_inst.write_word(FMEA_OFS, 16'h0000);
    rd(FMEA_OFS, 16'h1E20, 1'b1);
    over_temp <= 1'b1;
    repeat (5) @(posedge clk);
    over_temp <= 1'b0;
    balsw <= 12'h000;
    repeat (3) @(posedge clk);
    rd(FMEA_OFS, 16'h1E10, 1'b1);
    host_reg_model_inst.write_word(FMEA_OFS, 16'h0000);
    // Random source alerts, first pass all clear
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 32'h0 : xs();
      cell_ov <= r[11:0];
      cell_uv <= r[23:12];
      {a1o, a1u, a0o, a0u} <= r[27:24];
      balsw <= r[11:0] & {12{r[28]}};
      exp_cell = {2'b00, r[27] | r[26], r[25] | r[24], r[11:0] | r[23:12]};
      host_reg_model_inst.write_word(CELL_ALERT_OFS, 16'hFFFF);
      rd(CELL_ALERT_OFS, exp_cell, 1'b1);
      // Look between edges, where the live views have settled
      @(negedge clk);
      check({1'b0, cell_view}, {1'b0, exp_cell});
      check({1'b0, fmea}, {1'b0, 16'h1E00 | (16'(|(r[11:0] & {12{r[28]}})) << BALSW_BIT)});
    end
    {cell_ov, cell_uv, a1o, a1u, a0o, a0u, balsw} <= '0;
    // Primary oscillator stops: only the primary fault sets
    pri_hp = 0;
    repeat (150) @(posedge clk);
    pri_hp = 125;
    repeat (150) @(posedge clk);
    rd(FMEA_OFS, 16'h9E00, 1'b1);
    host_reg_model_inst.write_word(FMEA_OFS, 16'h7FFF);
    rd(FMEA_OFS, 16'h1E00, 1'b1);
    // Redundant slow by forty percent: each slow cycle alone is in range
    red_hp = 175;
    repeat (300) @(posedge clk);
    red_hp = 125;
    repeat (150) @(posedge clk);
    rd(FMEA_OFS, 16'h5E00, 1'b1);
    // Second reset in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    check({1'b0, fmea}, {1'b0, FMEA_RST});
    check({16'h0000, por_flag}, {16'h0000, POR_FLAG_RST});
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(STATUS_OFS, 16'h8000, 1'b1);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
